// >>> design/csll_pkg.sv
// Purpose: shared constants and carriers for the code security lock logic
// Assumes: byte-wide image space, 14-bit image address
// Notes:   image map covers user code, key array, lock option byte, status
package csll_pkg;

    // ---------------------------------------------------------------
    // widths and image map
    // ---------------------------------------------------------------
    localparam int          ADDR_W     = 14;
    localparam int          DATA_W     = 8;
    localparam int          CODE_AW    = 13;
    localparam int          KEY_AW     = 6;
    localparam int          CODE_BYTES = 8192;
    localparam int          KEY_BYTES  = 64;
    localparam logic [13:0] CODE_LAST  = 14'h1FFF;
    localparam logic [13:0] KEY_FIRST  = 14'h2000;
    localparam logic [13:0] KEY_LAST   = 14'h203F;
    localparam logic [13:0] LOCK_ADDR  = 14'h2040;
    localparam logic [13:0] STAT_ADDR  = 14'h2041;

    // ---------------------------------------------------------------
    // field positions and values
    // ---------------------------------------------------------------
    localparam int         LOCK1_BIT   = 0;
    localparam int         LOCK2_BIT   = 1;
    localparam int         STAT_L1     = 0;
    localparam int         STAT_L2     = 1;
    localparam int         STAT_ENC    = 2;
    localparam int         STAT_REF    = 3;
    localparam int         STAT_SEL    = 4;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [7:0] LOCK_RESET  = 8'hFF;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [1:0] SYNC_RESET  = 2'h0;

    // ---------------------------------------------------------------
    // carriers and states
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        req;
        logic        table_read;
        logic        from_ext;
        logic [12:0] addr;
    } csll_fetch_req_t;

    typedef struct packed {
        logic       valid;
        logic       blocked;
        logic [7:0] data;
    } csll_fetch_rsp_t;

    typedef enum logic [0:0] {SEL_CAPTURE, SEL_RUN} csll_sel_state_t;

endpackage : csll_pkg

// >>> design/csll_lock.sv
// Purpose: lock, encryption and readout control for on-chip code memory
// Assumes: resetn is power-on and erases key and locks; sys_reset is core reset
// Notes:   read data appear the cycle after the read strobe
`timescale 1ns/1ps
module csll_lock (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic                      sys_reset,
    // register port
    input  wire logic [13:0]               addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wstrobe,
    input  wire logic                      rstrobe,
    output logic [7:0]                     rdata,
    // core fetch path
    input  wire csll_pkg::csll_fetch_req_t fetch_req,
    output csll_pkg::csll_fetch_rsp_t      fetch_rsp,
    // pins and status
    input  wire logic                      external_access_select,
    output logic                           sel_effective,
    output logic                           verify_blocked
);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    // two stages so release is clean against clock
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rst_sync_ff <= csll_pkg::SYNC_RESET;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic in_range(input logic [13:0] a, lo, hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // key byte of ones leaves data unchanged, so blank key is plain
    function automatic logic [7:0] crypt(input logic [7:0] d, input logic [7:0] k);
        crypt = d ^ ~k;
    endfunction : crypt

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0]                   code_mem [csll_pkg::CODE_BYTES];
    logic [7:0]                   key_ff   [csll_pkg::KEY_BYTES];
    logic [7:0]                   nxt_key  [csll_pkg::KEY_BYTES];
    logic [7:0]                   lock_ff;
    logic [7:0]                   nxt_lock;
    logic                         refused_ff;
    logic                         nxt_refused;
    logic                         lock1;
    logic                         lock2;
    logic                         enc_active;
    logic                         code_we;
    logic                         w_code;
    logic                         w_key;
    logic                         w_lock;
    logic [csll_pkg::KEY_AW-1:0]  w_key_idx;

    // zero in a lock bit means programmed
    assign lock1 = ~lock_ff[csll_pkg::LOCK1_BIT];
    assign lock2 = ~lock_ff[csll_pkg::LOCK2_BIT];

    // encryption is on once any key byte leaves the erased value
    always_comb
    begin
        enc_active = 1'b0;
        for (int i = 0; i < csll_pkg::KEY_BYTES; i++)
            if (key_ff[i] != csll_pkg::BYTE_ERASED)
                enc_active = 1'b1;
    end

    // ---------------------------------------------------------------
    // programming writes
    // ---------------------------------------------------------------
    assign w_code    = in_range(addr, '0, csll_pkg::CODE_LAST);
    assign w_key     = in_range(addr, csll_pkg::KEY_FIRST, csll_pkg::KEY_LAST);
    assign w_lock    = (addr == csll_pkg::LOCK_ADDR);
    assign w_key_idx = addr[csll_pkg::KEY_AW-1:0];

    // key and lock bits only move toward zero, as a one-time cell would
    always_comb
    begin
        nxt_lock    = lock_ff;
        nxt_refused = refused_ff;
        code_we     = 1'b0;
        for (int i = 0; i < csll_pkg::KEY_BYTES; i++)
            nxt_key[i] = key_ff[i];
        if (wstrobe && (w_code || w_key || w_lock))
        begin
            nxt_refused = lock1;
            if (!lock1)
            begin
                code_we = w_code;
                if (w_key)
                    nxt_key[w_key_idx] = key_ff[w_key_idx] & wdata;
                if (w_lock)
                    nxt_lock = lock_ff & wdata;
            end
        end
    end

    // power-on leaves key and locks erased
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_ff    <= csll_pkg::LOCK_RESET;
            refused_ff <= 1'b0;
            for (int i = 0; i < csll_pkg::KEY_BYTES; i++)
                key_ff[i] <= csll_pkg::BYTE_ERASED;
        end
        else
        begin
            lock_ff    <= nxt_lock;
            refused_ff <= nxt_refused;
            for (int i = 0; i < csll_pkg::KEY_BYTES; i++)
                key_ff[i] <= nxt_key[i];
        end
    end

    // code array has no reset; it models the memory cells
    always_ff @(posedge clock)
    begin
        if (code_we)
            code_mem[addr[csll_pkg::CODE_AW-1:0]] <= wdata;
    end

    // ---------------------------------------------------------------
    // verify readout
    // ---------------------------------------------------------------
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] code_byte;
    logic [7:0] key_byte;

    assign code_byte = code_mem[addr[csll_pkg::CODE_AW-1:0]];
    assign key_byte  = key_ff[addr[csll_pkg::KEY_AW-1:0]];

    // code reads zero only with both locks set; key is hidden once lock 1 is set
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (rstrobe)
        begin
            nxt_rdata = csll_pkg::BYTE_ZERO;
            if (w_code && !(lock1 && lock2))
                nxt_rdata = enc_active ? crypt(code_byte, key_byte) : code_byte;
            else if (w_key && !lock1)
                nxt_rdata = key_byte;
            else if (w_lock)
                nxt_rdata = lock_ff;
            else if (addr == csll_pkg::STAT_ADDR)
            begin
                nxt_rdata[csll_pkg::STAT_L1]  = lock1;
                nxt_rdata[csll_pkg::STAT_L2]  = lock2;
                nxt_rdata[csll_pkg::STAT_ENC] = enc_active;
                nxt_rdata[csll_pkg::STAT_REF] = refused_ff;
                nxt_rdata[csll_pkg::STAT_SEL] = sel_effective;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= csll_pkg::BYTE_ZERO;
        else
            rdata_ff <= nxt_rdata;
    end
    assign rdata          = rdata_ff;
    assign verify_blocked = lock1 && lock2;

    // ---------------------------------------------------------------
    // external access latch
    // ---------------------------------------------------------------
    csll_pkg::csll_sel_state_t sel_state_ff;
    csll_pkg::csll_sel_state_t nxt_sel_state;
    logic                      sel_latch_ff;
    logic                      nxt_sel_latch;

    // pin is caught on the first cycle after any reset
    always_comb
    begin
        nxt_sel_state = sel_state_ff;
        nxt_sel_latch = sel_latch_ff;
        case (sel_state_ff)
            csll_pkg::SEL_CAPTURE:
            begin
                nxt_sel_latch = external_access_select;
                nxt_sel_state = csll_pkg::SEL_RUN;
            end
            csll_pkg::SEL_RUN:
            begin
                if (sys_reset)
                    nxt_sel_state = csll_pkg::SEL_CAPTURE;
            end
            default: nxt_sel_state = csll_pkg::SEL_CAPTURE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_state_ff <= csll_pkg::SEL_CAPTURE;
            sel_latch_ff <= 1'b0;
        end
        else
        begin
            sel_state_ff <= nxt_sel_state;
            sel_latch_ff <= nxt_sel_latch;
        end
    end

    // unlocked parts follow the live pin
    assign sel_effective = lock1 ? sel_latch_ff : external_access_select;

    // ---------------------------------------------------------------
    // core fetch path
    // ---------------------------------------------------------------
    csll_pkg::csll_fetch_rsp_t rsp_ff;
    csll_pkg::csll_fetch_rsp_t nxt_rsp;
    logic                      fetch_block;

    assign fetch_block = lock1 && fetch_req.table_read && fetch_req.from_ext;

    // internal fetches are never encrypted; only verify is
    always_comb
    begin
        nxt_rsp.valid   = fetch_req.req;
        nxt_rsp.blocked = fetch_req.req && fetch_block;
        nxt_rsp.data    = csll_pkg::BYTE_ZERO;
        if (fetch_req.req && !fetch_block)
            nxt_rsp.data = code_mem[fetch_req.addr];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rsp_ff <= '0;
        else
            rsp_ff <= nxt_rsp;
    end
    assign fetch_rsp = rsp_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // all checks sample on the core clock and sleep through reset
    default clocking cb_chk @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_code_read;
        rstrobe && w_code;
    endsequence

    sequence s_locked_write;
        wstrobe && lock1 && (w_code || w_key || w_lock);
    endsequence

    property p_plain_verify;
        s_code_read ##0 (!lock1 && !lock2 && !enc_active)
            |=> rdata == $past(code_byte);
    endproperty
    a_plain_verify: assert property (p_plain_verify) else $error("plain verify wrong");

    property p_enc_verify;
        s_code_read ##0 (enc_active && !(lock1 && lock2))
            |=> rdata == ($past(code_byte) ^ ~$past(key_byte));
    endproperty
    a_enc_verify: assert property (p_enc_verify) else $error("encrypted verify wrong");

    property p_table_block;
        (fetch_req.req && fetch_req.table_read && fetch_req.from_ext && lock1)
            |=> fetch_rsp.blocked && fetch_rsp.data == csll_pkg::BYTE_ZERO;
    endproperty
    a_table_block: assert property (p_table_block) else $error("locked table read leaked");

    property p_sel_hold;
        (sel_state_ff == csll_pkg::SEL_RUN && !sys_reset && lock1 && $past(lock1))
            |=> $stable(sel_effective);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("latched access select moved");

    property p_prog_refuse;
        s_locked_write |=> $stable(lock_ff) && refused_ff;
    endproperty
    a_prog_refuse: assert property (p_prog_refuse) else $error("locked write accepted");

    property p_verify_off;
        s_code_read ##0 (lock1 && lock2) |=> rdata == csll_pkg::BYTE_ZERO;
    endproperty
    a_verify_off: assert property (p_verify_off) else $error("verify not disabled");

    property p_key_blank;
        (rstrobe && w_key && !lock1 && !enc_active) |=> rdata == csll_pkg::BYTE_ERASED;
    endproperty
    a_key_blank: assert property (p_key_blank) else $error("blank key not all ones");

    property p_lock_read;
        (rstrobe && w_lock) |=> rdata == $past(lock_ff) && $past(lock1) == ~rdata[0];
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock byte readback wrong");

    property p_unmapped;
        (rstrobe && addr > csll_pkg::STAT_ADDR) |=> rdata == csll_pkg::BYTE_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule : csll_lock

// >>> test/csll_core_model.sv
// Purpose: core fetch path model issuing code fetches into the lock logic
// Assumes: request taken on the edge after it is raised, answer read 1 ns after that edge
// Notes:   address bus shows the inverse of the last address once released
`timescale 1ns/1ps
module csll_core_model (
    // clock
    input  wire logic                      clock,
    // fetch path toward the lock logic
    output csll_pkg::csll_fetch_req_t      fetch_req,
    input  wire csll_pkg::csll_fetch_rsp_t fetch_rsp
);
    // idle bus at time zero
    initial fetch_req = '0;

    // --------------------------------------------------------------
    // one fetch: raise, hold to the taking edge, then release
    // --------------------------------------------------------------
    task automatic fetch(input logic tread, input logic ext, input logic [12:0] a,
                         output csll_pkg::csll_fetch_rsp_t r);
        @(posedge clock);
        fetch_req <= '{1'b1, tread, ext, a};
        @(posedge clock);
        fetch_req.req  <= 1'b0;
        fetch_req.addr <= ~a; // stale address would hide a missed capture
        #1;
        r = fetch_rsp;
    endtask : fetch
endmodule : csll_core_model

// >>> test/csll_lock_tb.sv
// Purpose: self-checking bench for the code security lock logic
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes:   power-on reset is repeated to start the lock 2 scenario clean
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module csll_lock_tb;
    logic                      clock;
    logic                      resetn;
    logic                      sys_reset;
    logic [13:0]               addr;
    logic [7:0]                wdata;
    logic                      wstrobe;
    logic                      rstrobe;
    logic [7:0]                rdata;
    logic                      pin;
    logic                      sel_effective;
    logic                      verify_blocked;
    csll_pkg::csll_fetch_req_t fetch_req;
    csll_pkg::csll_fetch_rsp_t fetch_rsp;
    csll_pkg::csll_fetch_rsp_t rsp;
    int                        mismatches = 0;
    int                        tests_run = 0;

    csll_lock u_dut (
        .clock(clock), .resetn(resetn), .sys_reset(sys_reset),
        .addr(addr), .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata),
        .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
        .external_access_select(pin), .sel_effective(sel_effective),
        .verify_blocked(verify_blocked)
    );
    csll_core_model u_core (.clock(clock), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp));

    // 200 MHz core clock
    always #2.5 clock = ~clock;

    // --------------------------------------------------------------
    // access tasks
    // --------------------------------------------------------------
    task automatic do_por();
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock); // synchroniser needs two edges first
    endtask : do_por

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge clock);
        addr    <= a;
        wdata   <= d;
        wstrobe <= 1'b1;
        @(posedge clock);
        wstrobe <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
        @(posedge clock);
        addr    <= a;
        rstrobe <= 1'b1;
        @(posedge clock);
        rstrobe <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd_chk

    task automatic f_chk(input logic m, input logic x, input logic [12:0] a,
                         input logic b, input logic [7:0] d);
        u_core.fetch(m, x, a, rsp);
        `CHK({rsp.valid, rsp.blocked, rsp.data}, {1'b1, b, d})
    endtask : f_chk

    task automatic end_test(input string n);
        $display("test %s done, mismatches so far %0d", n, mismatches);
    endtask : end_test

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial
    begin
        clock = 1'b0; resetn = 1'b0; sys_reset = 1'b0; pin = 1'b1;
        addr = '0; wdata = '0; wstrobe = 1'b0; rstrobe = 1'b0;
        do_por();
        rd_chk(14'h2040, 8'hFF);
        rd_chk(14'h2000, 8'hFF);
        rd_chk(14'h203F, 8'hFF);
        rd_chk(14'h2041, 8'h10);
        rd_chk(14'h2042, 8'h00);
        wr(14'h0005, 8'hA5);
        wr(14'h1FFF, 8'h3C);
        wr(14'h0045, 8'h00);
        wr(14'h0000, 8'h11);
        rd_chk(14'h0005, 8'hA5);
        rd_chk(14'h1FFF, 8'h3C);
        f_chk(1'b1, 1'b1, 13'h0005, 1'b0, 8'hA5);
        end_test("plain");
        wr(14'h2005, 8'h0F);
        rd_chk(14'h2005, 8'h0F);
        rd_chk(14'h0005, 8'h55);
        rd_chk(14'h0045, 8'hF0);
        rd_chk(14'h0000, 8'h11);
        rd_chk(14'h2041, 8'h14);
        end_test("encrypt");
        wr(14'h2040, 8'hFE);
        rd_chk(14'h2040, 8'hFE);
        @(posedge clock);
        pin <= 1'b0;
        @(posedge clock);
        #1;
        `CHK(sel_effective, 1'b1)
        wr(14'h0005, 8'h00);
        rd_chk(14'h0005, 8'h55);
        rd_chk(14'h2041, 8'h1D);
        f_chk(1'b1, 1'b1, 13'h0005, 1'b1, 8'h00);
        f_chk(1'b1, 1'b0, 13'h0005, 1'b0, 8'hA5);
        `CHK(verify_blocked, 1'b0)
        @(posedge clock);
        sys_reset <= 1'b1;
        @(posedge clock);
        sys_reset <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        `CHK(sel_effective, 1'b0)
        end_test("lock1");
        @(posedge clock);
        pin <= 1'b1;
        do_por();
        wr(14'h0005, 8'hA5);
        wr(14'h2040, 8'hFC);
        #1;
        `CHK(verify_blocked, 1'b1)
        rd_chk(14'h0005, 8'h00);
        end_test("lock2");
        report_and_stop();
    end

    // watchdog: the sequence needs well under 300 cycles
    initial
    begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule : csll_lock_tb
